// >>> core/sic_pkg.sv
// Package: register map, field layout and timing constants of the sic block
package sic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses on the management path
  localparam logic [9:0] ADDR_CHIP_IDENTITY_REVISION = 10'h050;
  localparam logic [9:0] ADDR_BYTE_ORDER_PATTERN = 10'h064;
  localparam logic [9:0] ADDR_HARDWARE_CONFIGURATION = 10'h074;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ID_HI = 31;
  localparam int ID_LO = 16;
  localparam int REV_HI = 15;
  localparam int REV_LO = 0;
  localparam int READY_BIT = 27;
  localparam int XOVER_P2_BIT = 26;
  localparam int XOVER_P1_BIT = 25;
  localparam int HALF_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Constant values
  localparam logic [31:0] BYTE_ORDER_PATTERN = 32'h8765_4321;
  localparam logic [31:0] BYTE_ORDER_IN_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Arbitrary identity value, not tied to any real part
  localparam logic [15:0] CHIP_ID_DEFAULT = 16'hC5A1;
  // Arbitrary revision value, set per silicon revision
  localparam logic [15:0] CHIP_REV_DEFAULT = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // Extended management serial frame
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] OPCODE_BITS = 5'h02;
  localparam logic [4:0] ADDR_BITS = 5'h05;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam logic [4:0] SKIP_BITS = 5'h12;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam int SYS_SEL_BIT = 4;
  localparam int HALF_SEL_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Straps and pin synchroniser lanes
  localparam int STRAP_W = 2;
  localparam int P1 = 0;
  localparam int P2 = 1;
  localparam int SYNC_W = 5;
  localparam int SYNC_MDC = 0;
  localparam int SYNC_MDIO = 1;
  localparam int SYNC_EXT_RST_N = 2;
  localparam int SYNC_STRAP1 = 3;
  localparam int SYNC_STRAP2 = 4;
  localparam logic [4:0] SYNC_RESET_VAL = 5'h06;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int READY_DELAY_NS = 1000;
  localparam int READY_DELAY_CYCLES =
    (READY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READY_CNT_W = 8;

endpackage

// >>> core/sic_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
module sic_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Raw pins and filtered levels
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] level
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  ////////////////////////////////////////////////////////////////////////////
  // Stage chain; stage1 feeds only stage2
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end else begin
      stage1 <= pin_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A lane changes only once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      level <= RESET_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

endmodule // sic_pin_sync

// >>> core/sic_ready_ctrl.sv
// Ready timer and crossover strap latch of the sic block
`timescale 1ns/1ps
module sic_ready_ctrl
  import sic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic hold_reset,
  // Strap levels, already synchronised
  input wire logic [sic_pkg::STRAP_W-1:0] strap_level,
  // Configuration loader rewrite
  input wire logic eeprom_strap_we,
  input wire logic [sic_pkg::STRAP_W-1:0] eeprom_strap_data,
  // Results
  output logic device_ready,
  output logic [sic_pkg::STRAP_W-1:0] strap_latched
);

  localparam logic [READY_CNT_W-1:0] READY_LAST =
    READY_CNT_W'(READY_DELAY_CYCLES - 1);

  logic [READY_CNT_W-1:0] settle_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Settling timer; restarts on every reset source
  always_ff @(posedge clk) begin
    if (srst || hold_reset) begin
      settle_cnt <= '0;
      device_ready <= 1'b0;                         // [R7] [R8]
    end else if (!device_ready) begin
      if (settle_cnt == READY_LAST) begin
        device_ready <= 1'b1;                       // [R8]
      end else begin
        settle_cnt <= settle_cnt + 1'b1;
      end
    end
  end

  // Strap follows the pins during reset, freezes at release
  always_ff @(posedge clk) begin
    if (srst || hold_reset) begin
      strap_latched <= strap_level;                 // [R13] [R14]
    end else if (eeprom_strap_we) begin
      strap_latched <= eeprom_strap_data;           // [R15]
    end
  end

endmodule // sic_ready_ctrl

// >>> core/sic_regs.sv
// Identity, byte-order and hardware configuration registers with serial port
//
// What this block does
// R1: Identity upper half returns a fixed chip code; writes do nothing.
// R2: Identity lower half returns a read-only revision set per silicon.
// R3: Byte-order register returns the fixed 32-bit test pattern.
// R4: Byte-order register stays readable and harmless while not ready.
// R5: During reset the byte-order read never equals the valid pattern.
// R6: Either 16-bit half of byte-order and configuration reads alone.
// R7: Configuration bit 27 is a read-only ready flag, zero after reset.
// R8: Ready flag stays clear after any reset until the device settles.
// R9: Ready flag may raise an interrupt when its enable is set.
// R10: Host reads only config, byte-order, reset control while not ready; the block also answers identity reads then.
// R11: Writes before ready are invalid; host waits for the ready flag.
// R12: Configuration register may be polled in reset; data then invalid.
// R13: Bit 26 reports the port 2 crossover strap captured during reset.
// R14: Bit 25 reports the port 1 crossover strap captured during reset.
// R15: Configuration loader may rewrite latched straps; host writes cannot.
// R16: Per-port PHY crossover control and state override the latched strap.
// R17: Reserved bits read zero; all three registers ignore host writes.
`timescale 1ns/1ps
module sic_regs
  import sic_pkg::*;
#(
  parameter logic [15:0] CHIP_ID = sic_pkg::CHIP_ID_DEFAULT,
  parameter logic [15:0] CHIP_REV = sic_pkg::CHIP_REV_DEFAULT
) (
  // Clock and synchronous reset
  input wire logic clk,
  input wire logic srst,
  // Reset sources beyond the power-up reset
  input wire logic external_reset_pin_n,
  input wire logic digital_reset,
  // Extended management serial pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // Crossover strap pins
  input wire logic crossover_strap_p1,
  input wire logic crossover_strap_p2,
  // Configuration loader strap rewrite
  input wire logic eeprom_strap_we,
  input wire logic [sic_pkg::STRAP_W-1:0] eeprom_strap_data,
  // PHY crossover override per port
  input wire logic [sic_pkg::STRAP_W-1:0] crossover_override_control,
  input wire logic [sic_pkg::STRAP_W-1:0] crossover_override_state,
  // Ready notification
  input wire logic ready_irq_enable,
  output logic ready_irq,
  // Status toward the rest of the chip
  output logic device_ready,
  output logic [sic_pkg::STRAP_W-1:0] crossover_enable_strap_state,
  output logic write_dropped
);

  typedef enum {
    SIC_PREAMBLE,
    SIC_START,
    SIC_OPCODE,
    SIC_PHYAD,
    SIC_REGAD,
    SIC_TURN,
    SIC_DATA,
    SIC_SKIP
  } sic_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_level;
  logic mdc_level;
  logic mdc_prev;
  logic mdc_rise;
  logic mdio_level;
  logic hold_reset;
  logic in_reset;
  logic ready_int;
  logic ready_prev;
  logic [STRAP_W-1:0] strap_latched;
  logic [STRAP_W-1:0] strap_level;
  logic [STRAP_W-1:0] next_xover;
  sic_state_t state;
  logic [5:0] pre_cnt;
  logic [4:0] bit_cnt;
  logic [1:0] opcode;
  logic [4:0] phyad;
  logic [4:0] regad;
  logic [HALF_W-1:0] shift;
  logic [9:0] byte_addr;
  logic [31:0] read_word;
  logic [HALF_W-1:0] read_half;
  logic frame_is_read;

  ////////////////////////////////////////////////////////////////////////////
  // Word byte address of a frame: four phy bits, upper four reg bits
  function automatic logic [9:0] sic_word_addr(input logic [4:0] pa,
                                               input logic [4:0] ra);
    sic_word_addr = {pa[3:0], ra[4:1], 2'h0};
  endfunction

  // Pick one 16-bit half of a word, upper half when sel is set
  function automatic logic [HALF_W-1:0] sic_half(input logic [31:0] word,
                                                 input logic sel);
    sic_half = sel ? word[31:HALF_W] : word[HALF_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: all asynchronous pins share one bank
  always_comb begin
    pin_raw = '0;
    pin_raw[SYNC_MDC] = mdc;
    pin_raw[SYNC_MDIO] = mdio_in;
    pin_raw[SYNC_EXT_RST_N] = external_reset_pin_n;
    pin_raw[SYNC_STRAP1] = crossover_strap_p1;
    pin_raw[SYNC_STRAP2] = crossover_strap_p2;
  end

  sic_pin_sync #(
    .W(SYNC_W),
    .RESET_VAL(SYNC_RESET_VAL)
  ) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .pin_async(pin_raw),
    .level(pin_level)
  );

  // Filtered pin levels
  assign mdc_level = pin_level[SYNC_MDC];
  assign mdio_level = pin_level[SYNC_MDIO];
  assign strap_level[P1] = pin_level[SYNC_STRAP1];
  assign strap_level[P2] = pin_level[SYNC_STRAP2];

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources: pin reset and digital reset hold the core
  assign hold_reset = !pin_level[SYNC_EXT_RST_N] || digital_reset;

  // Registered reset state; the serial engine itself keeps running so
  // the host can poll during reset without any side effect
  always_ff @(posedge clk) begin
    if (srst) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= hold_reset;                        // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready timer and strap latch
  sic_ready_ctrl u_ready_ctrl (
    .clk(clk),
    .srst(srst),
    .hold_reset(hold_reset),
    .strap_level(strap_level),
    .eeprom_strap_we(eeprom_strap_we),
    .eeprom_strap_data(eeprom_strap_data),
    .device_ready(ready_int),
    .strap_latched(strap_latched)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ready flag output and its one-shot notification
  always_ff @(posedge clk) begin
    if (srst) begin
      device_ready <= 1'b0;
      ready_prev <= 1'b0;
      ready_irq <= 1'b0;
    end else begin
      device_ready <= ready_int;                     // [R7]
      ready_prev <= ready_int;
      // Pulse on the rising flag only; a late enable does not replay it
      ready_irq <= ready_irq_enable && ready_int && !ready_prev; // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossover enable per port: PHY override beats the latched strap
  always_comb begin
    for (int p = 0; p < STRAP_W; p++) begin
      next_xover[p] = crossover_override_control[p] ?
                      crossover_override_state[p] :
                      strap_latched[p];             // [R16]
    end
  end

  // Registered so the field and the PHY see the same value
  always_ff @(posedge clk) begin
    if (srst) begin
      crossover_enable_strap_state <= '0;
    end else begin
      crossover_enable_strap_state <= next_xover;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode
  always_comb begin
    read_word = WORD_ZERO;                           // [R17]
    case (byte_addr)
      ADDR_CHIP_IDENTITY_REVISION: begin
        read_word[ID_HI:ID_LO] = CHIP_ID;            // [R1]
        read_word[REV_HI:REV_LO] = CHIP_REV;         // [R2]
      end
      ADDR_BYTE_ORDER_PATTERN: begin
        // Invalid but never the real pattern while held in reset
        read_word = in_reset ? BYTE_ORDER_IN_RESET :
                    BYTE_ORDER_PATTERN;              // [R3] [R5]
      end
      ADDR_HARDWARE_CONFIGURATION: begin
        if (!in_reset) begin                         // [R12]
          read_word[READY_BIT] = device_ready;       // [R7]
          read_word[XOVER_P2_BIT] =
            crossover_enable_strap_state[P2];        // [R13]
          read_word[XOVER_P1_BIT] =
            crossover_enable_strap_state[P1];        // [R14]
        end
      end
      default: begin
        read_word = WORD_ZERO;
      end
    endcase
  end

  // Each half stands alone; no latching of the other half
  assign byte_addr = sic_word_addr(phyad, regad);
  assign read_half = sic_half(read_word, regad[HALF_SEL_BIT]); // [R6]
  assign frame_is_read = (opcode == OP_READ) && phyad[SYS_SEL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Clock edge detect on the filtered serial clock
  always_ff @(posedge clk) begin
    if (srst) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= mdc_level;
    end
  end

  assign mdc_rise = mdc_level && !mdc_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine; bits sampled on the rising serial clock
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= SIC_PREAMBLE;
      pre_cnt <= '0;
      bit_cnt <= '0;
      opcode <= '0;
      phyad <= '0;
      regad <= '0;
    end else if (mdc_rise) begin
      case (state)
        SIC_PREAMBLE: begin
          if (mdio_level) begin
            // Saturate so long idle runs stay valid preamble
            if (pre_cnt != PREAMBLE_LEN) begin
              pre_cnt <= pre_cnt + 1'b1;
            end
          end else if (pre_cnt == PREAMBLE_LEN) begin
            state <= SIC_START;
          end else begin
            pre_cnt <= '0;
          end
        end
        SIC_START: begin
          pre_cnt <= '0;
          bit_cnt <= '0;
          state <= mdio_level ? SIC_OPCODE : SIC_PREAMBLE;
        end
        SIC_OPCODE: begin
          opcode <= {opcode[0], mdio_level};
          if (bit_cnt == OPCODE_BITS - 1'b1) begin
            bit_cnt <= '0;
            state <= SIC_PHYAD;
          end else begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end
        SIC_PHYAD: begin
          phyad <= {phyad[3:0], mdio_level};
          if (bit_cnt == ADDR_BITS - 1'b1) begin
            bit_cnt <= '0;
            state <= SIC_REGAD;
          end else begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end
        SIC_REGAD: begin
          regad <= {regad[3:0], mdio_level};
          bit_cnt <= '0;
          if (bit_cnt == ADDR_BITS - 1'b1) begin
            // Decide from the completed address on the next edge
            state <= SIC_TURN;
          end else begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end
        SIC_TURN: begin
          // Host releases the line here; only system reads answer
          bit_cnt <= '0;
          state <= frame_is_read ? SIC_DATA : SIC_SKIP;
        end
        SIC_DATA: begin
          if (bit_cnt == DATA_BITS) begin
            bit_cnt <= '0;
            state <= SIC_PREAMBLE;
          end else begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end
        SIC_SKIP: begin
          // Rest of a write or a foreign frame: just count it out
          if (bit_cnt == SKIP_BITS - 1'b1 - 1'b1) begin
            bit_cnt <= '0;
            state <= SIC_PREAMBLE;
          end else begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end
        default: begin
          state <= SIC_PREAMBLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive: zero turnaround bit, then sixteen bits MSB first
  always_ff @(posedge clk) begin
    if (srst) begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b1;
      shift <= '0;
    end else if (mdc_rise) begin
      case (state)
        SIC_TURN: begin
          if (frame_is_read) begin
            mdio_oe <= 1'b1;
            mdio_out <= 1'b0;
            shift <= read_half;                      // [R6]
          end
        end
        SIC_DATA: begin
          if (bit_cnt == DATA_BITS) begin
            mdio_oe <= 1'b0;
            mdio_out <= 1'b1;
          end else begin
            mdio_out <= shift[HALF_W-1];
            shift <= {shift[HALF_W-2:0], 1'b0};
          end
        end
        default: begin
          mdio_oe <= 1'b0;
          mdio_out <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host writes to this bank never change state; flag them for the chip.
  // Writes before ready are invalid anyway, so no gating is needed here.
  always_ff @(posedge clk) begin
    if (srst) begin
      write_dropped <= 1'b0;
    end else begin
      write_dropped <= mdc_rise && (state == SIC_TURN) &&
                       (opcode == OP_WRITE) &&
                       phyad[SYS_SEL_BIT];           // [R11] [R17]
    end
  end

endmodule // sic_regs

// >>> dv/sic_regs_assertions.sv
// Port-level assertions of the sic register block
`timescale 1ns/1ps
module sic_regs_assertions
  import sic_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic srst,
  input wire logic external_reset_pin_n,
  input wire logic digital_reset,
  // Serial pins
  input wire logic mdc,
  input wire logic mdio_oe,
  // Straps and overrides
  input wire logic eeprom_strap_we,
  input wire logic [sic_pkg::STRAP_W-1:0] eeprom_strap_data,
  input wire logic [sic_pkg::STRAP_W-1:0] crossover_override_control,
  input wire logic [sic_pkg::STRAP_W-1:0] crossover_override_state,
  input wire logic [sic_pkg::STRAP_W-1:0] crossover_enable_strap_state,
  // Status
  input wire logic ready_irq,
  input wire logic device_ready,
  input wire logic write_dropped
);
  logic [7:0] quiet;
  logic [4:0] rises;
  logic mdc_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // Cycles since any reset source; saturates so it never wraps
  always_ff @(posedge clk) begin
    if (srst || digital_reset || !external_reset_pin_n) quiet <= 8'h00;
    else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
  end
  // Raw mdc rises while driven; the filter lag cancels at both ends
  always_ff @(posedge clk) begin
    mdc_q <= mdc;
    if (srst || !mdio_oe) rises <= 5'h00;
    else if (mdc && !mdc_q) rises <= rises + 5'h01;
  end
  a_irq_on_rise: assert property (ready_irq |-> $rose(device_ready))
    else $error("ready pulse without ready rise");
  a_irq_one_cycle: assert property (ready_irq |=> !ready_irq)
    else $error("ready pulse too long");
  a_hold_clears: assert property (digital_reset [*3] |-> !device_ready)
    else $error("ready set while held");
  a_ready_not_early: assert property ($rose(device_ready) |->
    quiet >= 8'h28)
    else $error("ready rose too soon");
  a_ready_in_time: assert property (quiet == 8'h32 |-> device_ready)
    else $error("ready late");
  a_override_p1: assert property (crossover_override_control[P1] &&
    !digital_reset |=> crossover_enable_strap_state[P1] ==
    $past(crossover_override_state[P1]))
    else $error("port 1 override ignored");
  a_override_p2: assert property (crossover_override_control[P2] &&
    !digital_reset |=> crossover_enable_strap_state[P2] ==
    $past(crossover_override_state[P2]))
    else $error("port 2 override ignored");
  a_loader_rewrite: assert property (eeprom_strap_we &&
    crossover_override_control == 2'h0 && !digital_reset &&
    external_reset_pin_n |-> ##2 (crossover_override_control != 2'h0 ||
    crossover_enable_strap_state == $past(eeprom_strap_data, 2)))
    else $error("loader strap value not taken");
  a_read_length: assert property ($fell(mdio_oe) |-> rises == 5'h11)
    else $error("read answer has wrong length");
  a_write_silent: assert property (write_dropped |-> !mdio_oe)
    else $error("write frame answered");
  // Main scenarios reached
  c_ready_irq: cover property ($rose(device_ready) && ready_irq);
  c_read_done: cover property ($fell(mdio_oe));
  c_write_drop: cover property (write_dropped);
endmodule // sic_regs_assertions

bind sic_regs sic_regs_assertions u_sic_regs_assertions (.clk, .srst,
  .external_reset_pin_n, .digital_reset, .mdc, .mdio_oe, .eeprom_strap_we,
  .eeprom_strap_data, .crossover_override_control, .crossover_override_state,
  .crossover_enable_strap_state, .ready_irq, .device_ready, .write_dropped);

// >>> dv/sic_host_model.sv
// Host side of the serial management link, frame by frame
`timescale 1ns/1ps
module sic_host_model #(
  parameter int HALF = 8
) (
  // Clock and resolved data line
  input wire logic clk,
  input wire logic mdio_wire,
  // Pins the host drives
  output logic mdc,
  output logic host_oe,
  output logic host_bit
);
  ////////////////////////////////////////
  // Idle: clock still, data released to the pull-up
  initial begin
    mdc = 1'h0;
    host_oe = 1'h0;
    host_bit = 1'h1;
  end
  // One bit; data changes with mdc low, line sampled before the rise
  task automatic bit_cycle(input logic b, output logic s);
    mdc = 1'h0;
    host_bit = b;
    repeat (HALF) @(negedge clk);
    s = mdio_wire;
    mdc = 1'h1;
    repeat (HALF) @(negedge clk);
  endtask
  // Whole frame with its own preamble; reads release the line at turnaround
  task automatic xfer(input logic wr, input logic [9:0] addr,
      input logic hi, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic s;
    f = {32'hFFFF_FFFF, 2'h1, wr ? 2'h1 : 2'h2, 1'h1, addr[9:2], hi,
      wr ? 2'h2 : 2'h3, wd};
    rd = 16'h0000;
    @(negedge clk);
    host_oe = 1'h1;
    for (int i = 0; i < 64; i++) begin
      if (!wr && i == 46) host_oe = 1'h0;
      bit_cycle(f[63-i], s);
      if (i >= 48) rd = {rd[14:0], s};
    end
    mdc = 1'h0;
    host_oe = 1'h0;
    host_bit = 1'h1;
  endtask
endmodule // sic_host_model

// >>> dv/test_sic_regs.sv
// Self-checking bench of the sic register block
`timescale 1ns/1ps
module test_sic_regs;
  import sic_pkg::*;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic ext_n = 1'h1;
  logic drst = 1'h0;
  logic strap1 = 1'h1;
  logic strap2 = 1'h0;
  logic ee_we = 1'h0;
  logic [1:0] ee_d = 2'h0;
  logic [1:0] ov_c = 2'h0;
  logic [1:0] ov_s = 2'h0;
  logic irq_en = 1'h1;
  logic mdc, mdio_out, mdio_oe, h_oe, h_bit, irq, rdy, wdrop;
  logic [1:0] xs;
  logic [15:0] rd;
  // Pulled-up line: block, then host, else pull-up
  wire logic mdio_wire = mdio_oe ? mdio_out : (h_oe ? h_bit : 1'h1);
  int n_fail = 0;
  int samples_checked = 0;
  int irqs = 0;
  int drops = 0;
  int n;
  int d0;
  logic [26:0] rows [7] = '{
    {ADDR_CHIP_IDENTITY_REVISION, 1'h1, CHIP_ID_DEFAULT},
    {ADDR_CHIP_IDENTITY_REVISION, 1'h0, CHIP_REV_DEFAULT},
    {ADDR_BYTE_ORDER_PATTERN, 1'h1, 16'h8765},
    {ADDR_BYTE_ORDER_PATTERN, 1'h0, 16'h4321},
    {ADDR_HARDWARE_CONFIGURATION, 1'h1, 16'h0A00},
    {ADDR_HARDWARE_CONFIGURATION, 1'h0, 16'h0000},
    {10'h058, 1'h1, 16'h0000}};
  ////////////////////////////////////////
  sic_regs u_sic_regs (.clk(clk), .srst(srst), .external_reset_pin_n(ext_n),
    .digital_reset(drst), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .crossover_strap_p1(strap1),
    .crossover_strap_p2(strap2), .eeprom_strap_we(ee_we),
    .eeprom_strap_data(ee_d), .crossover_override_control(ov_c),
    .crossover_override_state(ov_s), .ready_irq_enable(irq_en),
    .ready_irq(irq), .device_ready(rdy), .crossover_enable_strap_state(xs),
    .write_dropped(wdrop));
  sic_host_model u_sic_host_model (.clk(clk), .mdio_wire(mdio_wire),
    .mdc(mdc), .host_oe(h_oe), .host_bit(h_bit));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Pulse counters, read away from the launching edge
  always @(negedge clk) begin
    if (irq === 1'h1) irqs++;
    if (wdrop === 1'h1) drops++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rd_chk(logic [9:0] a, logic hi, logic [15:0] e);
    u_sic_host_model.xfer(1'h0, a, hi, 16'h0000, rd);
    check({16'h0000, rd}, {16'h0000, e});
  endtask
  // Bounded wait for the ready flag; a hang counts as a mismatch
  task automatic wait_ready;
    n = 0;
    while (rdy !== 1'h1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic run_rows;
    foreach (rows[i]) rd_chk(rows[i][26:17], rows[i][16], rows[i][15:0]);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    check({rdy, mdio_oe, mdio_out, irq, wdrop, xs}, 32'h0000_0010);
    srst = 1'h0;
    drst = 1'h1;
    // Held core: only byte-order and configuration are polled
    rd_chk(ADDR_BYTE_ORDER_PATTERN, 1'h1, 16'h0000);
    rd_chk(ADDR_BYTE_ORDER_PATTERN, 1'h0, 16'h0000);
    rd_chk(ADDR_HARDWARE_CONFIGURATION, 1'h1, 16'h0000);
    check(xs, 32'h0000_0001);
    // Early write, meant to be dropped
    u_sic_host_model.xfer(1'h1, ADDR_HARDWARE_CONFIGURATION, 1'h1,
      16'hFFFF, rd);
    drst = 1'h0;
    wait_ready();
    check(n >= 40 && n <= 48, 32'h0000_0001);
    repeat (2) @(negedge clk);
    check(irqs, 32'h0000_0001);
    run_rows();
    // Host writes to every register change nothing
    d0 = drops;
    u_sic_host_model.xfer(1'h1, ADDR_CHIP_IDENTITY_REVISION, 1'h1,
      16'hFFFF, rd);
    u_sic_host_model.xfer(1'h1, ADDR_BYTE_ORDER_PATTERN, 1'h0,
      16'h0000, rd);
    u_sic_host_model.xfer(1'h1, ADDR_HARDWARE_CONFIGURATION, 1'h1,
      16'hFFFF, rd);
    check(drops - d0, 32'h0000_0003);
    run_rows();
    // Loader rewrites the latched straps
    ee_d = 2'h2;
    ee_we = 1'h1;
    @(negedge clk);
    ee_we = 1'h0;
    repeat (2) @(negedge clk);
    check(xs, 32'h0000_0002);
    rd_chk(ADDR_HARDWARE_CONFIGURATION, 1'h1, 16'h0C00);
    // PHY overrides win over the latch
    ov_c = 2'h1;
    ov_s = 2'h1;
    repeat (2) @(negedge clk);
    check(xs, 32'h0000_0003);
    ov_c = 2'h3;
    repeat (2) @(negedge clk);
    check(xs, 32'h0000_0001);
    rd_chk(ADDR_HARDWARE_CONFIGURATION, 1'h1, 16'h0A00);
    ov_c = 2'h0;
    // Pin reset recaptures straps, no pulse with enable off
    irq_en = 1'h0;
    strap2 = 1'h1;
    ext_n = 1'h0;
    repeat (10) @(negedge clk);
    check(rdy, 32'h0000_0000);
    ext_n = 1'h1;
    wait_ready();
    check(n >= 40 && n <= 52, 32'h0000_0001);
    repeat (2) @(negedge clk);
    check(irqs, 32'h0000_0001);
    check(xs, 32'h0000_0003);
    end_sim();
  end
endmodule // test_sic_regs
